// file: logic/gcr_params.svh
// Function
// [R01] Read-only 15-bit code holds the latest delay-block calibration result.
// [R02] Writing one to delay calibration command starts it; self-clears; result stored.
// [R03] Host should issue the delay calibration command during startup.
// [R04] Read-only startup flag: zero while startup runs, one when ready.
// [R05] Writing one to divider init command initialises dividers and phase delays.
// [R06] Host issues divider init at startup and after every divider or delay change.
// [R07] Writing one to bias calibration command starts it; clears when calibration ends.
// [R08] Host must issue the bias calibration command during startup.
// [R09] Read-edge select resets zero: zero shifts on falling SCLK, one on rising.
// [R10] Writing one to alignment enable arms alignment at next reference rising edge.
// [R11] Alignment enable resets to zero, alignment stays off until set.
// [R12] Command bits and reserved bits read as zero.
// [R13] Host samples read data on the SCLK edge opposite the selected one.
`ifndef GCR_PARAMS_SVH
`define GCR_PARAMS_SVH

`define GCR_ADDR_CODE_HI  8'h6C
`define GCR_ADDR_CODE_LO  8'h6D
`define GCR_ADDR_STATUS   8'h6E
`define GCR_ADDR_BIAS     8'h6F
`define GCR_ADDR_DIV_INIT 8'h70
`define GCR_ADDR_DLY_CAL  8'h71
`define GCR_ADDR_BIAS_CAL 8'h72
`define GCR_ADDR_ALIGN    8'h73

`define GCR_BIT_CMD       7
`define GCR_BIT_READY     1
`define GCR_BIT_EDGE      0
`define GCR_CODE_W        15
`define GCR_BIAS_W        6
`define GCR_SYNC_STAGES   2
`define GCR_ALIGN_RESET   1'h0
`define GCR_EDGE_RESET    1'h0

`endif

// file: logic/gcr_pkg.sv
`default_nettype none
package gcr_pkg;
   // Progress of one calibration engine
   typedef enum logic {
      CAL_IDLE,
      CAL_BUSY
   } gcr_cal_state_type;
endpackage
`default_nettype wire

// file: logic/gcr_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "gcr_params.svh"
module gcr_regs (
   input  wire  logic                   core_clk_i,
   input  wire  logic                   rst_i,
   // Register port from the serial configuration engine
   input  wire  logic [7:0]             reg_addr_i,
   input  wire  logic                   reg_wr_i,
   input  wire  logic [7:0]             reg_wdata_i,
   input  wire  logic                   reg_rd_i,
   output logic       [7:0]             reg_rdata_o,
   output logic                         reg_rvalid_o,
   // Analog and calibration side
   input  wire  logic                   startup_done_i,
   input  wire  logic                   ref_in_i,
   input  wire  logic                   delay_cal_done_i,
   input  wire  logic [`GCR_CODE_W-1:0] delay_cal_code_i,
   input  wire  logic                   bias_cal_done_i,
   input  wire  logic [`GCR_BIAS_W-1:0] bias_level_i,
   output logic                         divider_init_o,
   output logic                         delay_block_cal_start_o,
   output logic                         precision_bias_cal_start_o,
   output logic                         multi_buffer_align_en_o,
   output logic                         align_start_o,
   output logic                         read_edge_select_o
);
   logic [1:0]                   sync_w;
   logic                         ref_sync;
   logic                         ready_sync;
   logic                         ref_prev_q, ref_prev_d;
   logic                         ref_rise;
   gcr_pkg::gcr_cal_state_type   dly_state_q, dly_state_d;
   gcr_pkg::gcr_cal_state_type   bias_state_q, bias_state_d;
   logic [`GCR_CODE_W-1:0]       code_q, code_d;
   logic [`GCR_BIAS_W-1:0]       bias_q, bias_d;
   logic                         div_init_d, dly_start_d, bias_start_d;
   logic                         align_d, align_start_d, edge_d;
   logic [7:0]                   rdata_d;
   logic                         rvalid_d;

   // The read mux splits the code as 7 + 8 bits and pads the bias to a byte
   if ((`GCR_CODE_W != 15) || (`GCR_BIAS_W != 6)) begin : g_width_check
      $error("gcr_regs: code must be 15 bits and bias 6 bits");
   end

   // Pins from outside the clock domain
   gcr_sync #(
      .WIDTH (2)
   ) u_sync (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .async_i    ({startup_done_i, ref_in_i}),
      .sync_o     (sync_w)
   );
   assign ref_sync   = sync_w[0];
   assign ready_sync = sync_w[1];
   assign ref_rise   = ref_sync && !ref_prev_q;

   // A write carrying a one in the command position of one address
   function automatic logic cmd_write(input logic       wr,
                                      input logic [7:0] addr,
                                      input logic [7:0] data,
                                      input logic [7:0] target);
      cmd_write = wr && (addr == target) && data[`GCR_BIT_CMD];
   endfunction

   // Next-state logic for commands, results, alignment and read data
   always_comb begin
      ref_prev_d    = ref_sync;
      dly_state_d   = dly_state_q;
      bias_state_d  = bias_state_q;
      code_d        = code_q;
      bias_d        = bias_q;
      align_d       = multi_buffer_align_en_o;
      edge_d        = read_edge_select_o;
      align_start_d = 1'b0;
      dly_start_d   = 1'b0;
      bias_start_d  = 1'b0;
      div_init_d    = cmd_write(reg_wr_i, reg_addr_i, reg_wdata_i, `GCR_ADDR_DIV_INIT); // R05

      // Delay block calibration; a repeat write while running is ignored
      unique case (dly_state_q)
         gcr_pkg::CAL_IDLE: begin
            if (cmd_write(reg_wr_i, reg_addr_i, reg_wdata_i, `GCR_ADDR_DLY_CAL)) begin
               dly_state_d = gcr_pkg::CAL_BUSY; // R02
               dly_start_d = 1'b1;
            end
         end
         gcr_pkg::CAL_BUSY: begin
            if (delay_cal_done_i) begin
               dly_state_d = gcr_pkg::CAL_IDLE;
               code_d      = delay_cal_code_i; // R01
            end
         end
      endcase

      // Bias calibration; command stays pending until the engine finishes
      unique case (bias_state_q)
         gcr_pkg::CAL_IDLE: begin
            if (cmd_write(reg_wr_i, reg_addr_i, reg_wdata_i, `GCR_ADDR_BIAS_CAL)) begin
               bias_state_d = gcr_pkg::CAL_BUSY; // R07
               bias_start_d = 1'b1;
            end
         end
         gcr_pkg::CAL_BUSY: begin
            if (bias_cal_done_i) begin
               bias_state_d = gcr_pkg::CAL_IDLE; // R07
               bias_d       = bias_level_i;
            end
         end
      endcase

      // Armed alignment fires on the next reference rise, then disarms
      if (multi_buffer_align_en_o && ref_rise) begin
         align_d       = 1'b0; // R10
         align_start_d = 1'b1;
      end
      // Written last so a set in the same cycle as the edge wins
      if (reg_wr_i && (reg_addr_i == `GCR_ADDR_ALIGN)) begin
         align_d = reg_wdata_i[`GCR_BIT_CMD]; // R10
         edge_d  = reg_wdata_i[`GCR_BIT_EDGE]; // R09
      end

      // Read mux; unmapped and command addresses return zero
      rvalid_d = reg_rd_i;
      rdata_d  = 8'h00; // R12
      if (reg_rd_i) begin
         case (reg_addr_i)
            `GCR_ADDR_CODE_HI: rdata_d = {1'b0, code_q[`GCR_CODE_W-1:8]}; // R01
            `GCR_ADDR_CODE_LO: rdata_d = code_q[7:0];
            `GCR_ADDR_STATUS:  rdata_d = {6'h00, ready_sync, 1'b0}; // R04
            `GCR_ADDR_BIAS:    rdata_d = {2'h0, bias_q};
            `GCR_ADDR_ALIGN:   rdata_d = {multi_buffer_align_en_o, 6'h00, read_edge_select_o};
            default:           rdata_d = 8'h00; // R12
         endcase
      end
   end

   // State registers; result registers hold zero until the first run
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ref_prev_q                 <= 1'b0;
         dly_state_q                <= gcr_pkg::CAL_IDLE;
         bias_state_q               <= gcr_pkg::CAL_IDLE;
         code_q                     <= '0;
         bias_q                     <= '0;
         divider_init_o             <= 1'b0;
         delay_block_cal_start_o    <= 1'b0;
         precision_bias_cal_start_o <= 1'b0;
         multi_buffer_align_en_o    <= `GCR_ALIGN_RESET; // R11
         align_start_o              <= 1'b0;
         read_edge_select_o         <= `GCR_EDGE_RESET; // R09
         reg_rdata_o                <= 8'h00;
         reg_rvalid_o               <= 1'b0;
      end else begin
         ref_prev_q                 <= ref_prev_d;
         dly_state_q                <= dly_state_d;
         bias_state_q               <= bias_state_d;
         code_q                     <= code_d;
         bias_q                     <= bias_d;
         divider_init_o             <= div_init_d;
         delay_block_cal_start_o    <= dly_start_d;
         precision_bias_cal_start_o <= bias_start_d;
         multi_buffer_align_en_o    <= align_d;
         align_start_o              <= align_start_d;
         read_edge_select_o         <= edge_d;
         reg_rdata_o                <= rdata_d;
         reg_rvalid_o               <= rvalid_d;
      end
   end

   // Checks sleep while reset is held, so pin sync settling is not flagged
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   div_init_pulse_a: assert property ( // R05
      reg_wr_i && reg_addr_i == `GCR_ADDR_DIV_INIT && reg_wdata_i[7] |=> divider_init_o)
      else $error("divider init pulse missing");
   dly_cal_start_a: assert property ( // R02
      reg_wr_i && reg_addr_i == `GCR_ADDR_DLY_CAL && reg_wdata_i[7] && dly_state_q == gcr_pkg::CAL_IDLE
      |=> delay_block_cal_start_o ##1 !delay_block_cal_start_o)
      else $error("delay cal start not a single pulse");
   code_store_a: assert property ( // R01
      dly_state_q == gcr_pkg::CAL_BUSY && delay_cal_done_i |=> code_q == $past(delay_cal_code_i))
      else $error("calibration code not stored");
   bias_busy_a: assert property ( // R07
      bias_state_q == gcr_pkg::CAL_BUSY && bias_cal_done_i
      |=> bias_state_q == gcr_pkg::CAL_IDLE && bias_q == $past(bias_level_i))
      else $error("bias calibration did not finish and store");
   ready_read_a: assert property ( // R04
      reg_rd_i && reg_addr_i == `GCR_ADDR_STATUS |=> reg_rvalid_o && reg_rdata_o == {6'h00, $past(ready_sync), 1'b0})
      else $error("startup flag read wrong");
   edge_write_a: assert property ( // R09
      reg_wr_i && reg_addr_i == `GCR_ADDR_ALIGN |=> read_edge_select_o == $past(reg_wdata_i[0]))
      else $error("read edge select not written");
   align_fire_a: assert property ( // R10
      multi_buffer_align_en_o && ref_rise && !(reg_wr_i && reg_addr_i == `GCR_ADDR_ALIGN)
      |=> align_start_o && !multi_buffer_align_en_o)
      else $error("alignment did not start and clear");
   align_armed_a: assert property ( // R11
      align_start_o |-> $past(multi_buffer_align_en_o))
      else $error("alignment started unarmed");
   cmd_read_zero_a: assert property ( // R12
      reg_rd_i && (reg_addr_i == `GCR_ADDR_DIV_INIT || reg_addr_i == `GCR_ADDR_DLY_CAL
      || reg_addr_i == `GCR_ADDR_BIAS_CAL) |=> reg_rdata_o == 8'h00)
      else $error("command register read nonzero");
   dly_busy_ignore_a: assert property ( // R02
      reg_wr_i && reg_addr_i == `GCR_ADDR_DLY_CAL && dly_state_q == gcr_pkg::CAL_BUSY
      |=> !delay_block_cal_start_o)
      else $error("delay cal restarted while busy");
   bias_cal_start_a: assert property ( // R07
      reg_wr_i && reg_addr_i == `GCR_ADDR_BIAS_CAL && reg_wdata_i[`GCR_BIT_CMD]
      && bias_state_q == gcr_pkg::CAL_IDLE
      |=> precision_bias_cal_start_o ##1 !precision_bias_cal_start_o)
      else $error("bias cal start not a single pulse");
   align_write_a: assert property ( // R10
      reg_wr_i && reg_addr_i == `GCR_ADDR_ALIGN |=> multi_buffer_align_en_o == $past(reg_wdata_i[`GCR_BIT_CMD]))
      else $error("alignment enable not written");
   align_pulse_a: assert property ( // R10
      align_start_o |=> !align_start_o)
      else $error("alignment start longer than one cycle");
   rdata_idle_a: assert property ( // R12
      !reg_rd_i |=> !reg_rvalid_o && reg_rdata_o == 8'h00)
      else $error("read data shown without a read");
endmodule
`default_nettype wire

// file: logic/gcr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module gcr_sync #(
   parameter int WIDTH = 1
) (
   input  wire  logic             core_clk_i,
   input  wire  logic             rst_i,
   input  wire  logic [WIDTH-1:0] async_i,
   output logic       [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_q;

   // Refused at elaboration; a zero-width bus has no meaning here
   if (WIDTH < 1) begin : g_width_check
      $error("gcr_sync: WIDTH must be at least 1");
   end

   // Two stages; the first stage feeds only the second
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= '0;
         sync_o <= '0;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule
`default_nettype wire

// file: testbench/gcr_cal_model.sv
`timescale 1ns/1ps
`default_nettype none
module gcr_cal_model (
   input  wire  logic        core_clk_i,
   input  wire  logic        rst_i,
   input  wire  logic [3:0]  lat_i,
   input  wire  logic        dly_start_i,
   input  wire  logic        bias_start_i,
   input  wire  logic [14:0] val_i,
   output logic              dly_done_o,
   output logic              bias_done_o,
   output logic [14:0]       code_o,
   output logic [5:0]        level_o
);
   logic [3:0] cnt_q;
   logic       is_bias_q;
   // One engine at a time; lat_i sets how long it stalls before done
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q     <= 4'h0;
         is_bias_q <= 1'h0;
      end else if (dly_start_i | bias_start_i) begin
         cnt_q     <= lat_i;
         is_bias_q <= bias_start_i;
      end else if (cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
      end
   end
   assign dly_done_o  = (cnt_q == 4'h1) & ~is_bias_q;
   assign bias_done_o = (cnt_q == 4'h1) & is_bias_q;
   // Inverted outside done, so a capture at the wrong time shows up
   assign code_o  = (cnt_q == 4'h1) ? val_i : ~val_i;
   assign level_o = (cnt_q == 4'h1) ? val_i[5:0] : ~val_i[5:0];
endmodule
`default_nettype wire

// file: testbench/test_gcr_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "gcr_params.svh"
module test_gcr_regs;
   logic        clk, rst, wr, rd, st_done, ref_in, rvalid, div_init, dstart, bstart, al_en, al_start;
   logic        redge, ddone, bdone;
   logic [7:0]  addr, wdata, rdata;
   logic [3:0]  lat;
   logic [5:0]  blev;
   logic [14:0] val, code;
   logic        host_sample_rise;
   int          bad_count = 0;
   int          total_checks = 0;
   gcr_regs dut (.core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
      .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .startup_done_i(st_done),
      .ref_in_i(ref_in), .delay_cal_done_i(ddone), .delay_cal_code_i(code), .bias_cal_done_i(bdone),
      .bias_level_i(blev), .divider_init_o(div_init), .delay_block_cal_start_o(dstart),
      .precision_bias_cal_start_o(bstart), .multi_buffer_align_en_o(al_en), .align_start_o(al_start),
      .read_edge_select_o(redge));
   gcr_cal_model cal (.core_clk_i(clk), .rst_i(rst), .lat_i(lat), .dly_start_i(dstart),
      .bias_start_i(bstart), .val_i(val), .dly_done_o(ddone), .bias_done_o(bdone),
      .code_o(code), .level_o(blev));
   // Host samples read data on the edge opposite the one the device shifts on
   assign host_sample_rise = ~redge;
   task automatic chk(input logic [14:0] seen, input logic [14:0] want);
      total_checks++;
      if (seen !== want) begin
         bad_count++;
         $display("mismatch at %0t ns: saw %h want %h", $time, seen, want);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic note(input string s);
      $display("test %s done", s);
   endtask
   // One write strobe; its effect lands the cycle after
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'h1;
      @(posedge clk);
      wr    <= 1'h0;
   endtask
   // Read data only stands in the single valid cycle, so look there
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] want);
      @(posedge clk);
      addr <= a;
      rd   <= 1'h1;
      @(posedge clk);
      rd   <= 1'h0;
      @(negedge clk);
      chk(15'(rvalid), 15'h1);
      chk(15'(rdata), 15'(want));
   endtask
   // Bounded wait for a strobe; running out ends the run
   task automatic wait_for(input int sel);
      logic [2:0] seen;
      for (int i = 0; i < 20; i++) begin
         @(negedge clk);
         seen = {bdone, ddone, al_start};
         if (seen[sel] === 1'h1) return;
      end
      bad_count++;
      $display("mismatch at %0t ns: strobe %0d never came", $time, sel);
      complete_run();
   endtask
   initial begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      rst     = 1'h1;
      addr    = 8'h00;
      wdata   = 8'h00;
      wr      = 1'h0;
      rd      = 1'h0;
      st_done = 1'h0;
      ref_in  = 1'h0;
      lat     = 4'h1;
      val     = 15'h0000;
      repeat (12) @(posedge clk);
      rst <= 1'h0;
      // Out of reset: startup pending, alignment off, falling-edge reads
      rd_reg(`GCR_ADDR_STATUS, 8'h00);
      rd_reg(`GCR_ADDR_ALIGN, 8'h00);
      chk(15'(redge), 15'h0);
      // A reference edge while disarmed must start nothing
      @(posedge clk);
      ref_in <= 1'h1;
      repeat (6) @(negedge clk) chk(15'(al_start), 15'h0);
      @(posedge clk);
      ref_in  <= 1'h0;
      st_done <= 1'h1;
      repeat (4) @(posedge clk);
      rd_reg(`GCR_ADDR_STATUS, 8'h02);
      for (int a = 8'h70; a < 8'h73; a++) rd_reg(8'(a), 8'h00);
      rd_reg(8'h50, 8'h00);
      note("reset");
      // Divider init pulses once per bit-7 write, never for other bits
      wr_reg(`GCR_ADDR_DIV_INIT, 8'h80);
      @(negedge clk) chk(15'(div_init), 15'h1);
      @(negedge clk) chk(15'(div_init), 15'h0);
      wr_reg(`GCR_ADDR_DIV_INIT, 8'h7F);
      repeat (2) @(negedge clk) chk(15'(div_init), 15'h0);
      // Delay calibration, prompt then slow engine
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         lat <= 4'(1 + 6 * i);
         val <= 15'(16'h5A3C >> i);
         wr_reg(`GCR_ADDR_DLY_CAL, 8'h80);
         @(negedge clk) chk(15'(dstart), 15'h1);
         if (i == 1) begin
            // A repeat command while the slow engine runs is dropped
            wr_reg(`GCR_ADDR_DLY_CAL, 8'h80);
            @(negedge clk) chk(15'(dstart), 15'h0);
         end
         wait_for(1);
         rd_reg(`GCR_ADDR_CODE_HI, 8'(val >> 8));
         rd_reg(`GCR_ADDR_CODE_LO, val[7:0]);
      end
      wr_reg(`GCR_ADDR_BIAS_CAL, 8'h80);
      @(negedge clk) chk(15'(bstart), 15'h1);
      wait_for(2);
      rd_reg(`GCR_ADDR_BIAS, {2'h0, val[5:0]});
      note("commands");
      // Arm alignment with rising-edge reads, then a reference edge fires it
      wr_reg(`GCR_ADDR_ALIGN, 8'h81);
      @(negedge clk) chk(15'({al_en, redge}), 15'h3);
      chk(15'(host_sample_rise), 15'h0);
      @(posedge clk);
      ref_in <= 1'h1;
      wait_for(0);
      chk(15'(al_en), 15'h0);
      rd_reg(`GCR_ADDR_ALIGN, 8'h01);
      // Arm with falling-edge reads, then a zero write disarms without an edge
      wr_reg(`GCR_ADDR_ALIGN, 8'h80);
      @(negedge clk) chk(15'({al_en, redge}), 15'h2);
      wr_reg(`GCR_ADDR_ALIGN, 8'h00);
      @(negedge clk) chk(15'(al_en), 15'h0);
      chk(15'(host_sample_rise), 15'h1);
      note("align");
      complete_run();
   end
endmodule
`default_nettype wire
